/* rtl/sci_flags_and_request_routing.sv */
// Status flags, ninth bits and request routing of the serial interface
`timescale 1ns/100ps
`default_nettype none
`include "sci_flags_consts.svh"
module sci_flags_and_request_routing (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // Avalon-MM slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // DMA data register port
  input wire logic dma_rd_i,
  input wire logic dma_wr_i,
  input wire logic [7:0] dma_wdata_i,
  output logic [7:0] dma_rdata_o,
  // Receiver side
  input wire sci_flags_pkg::rx_event_t rx_ev_i,
  input wire logic rx_idle_i,
  input wire logic rx_enable_i,
  input wire logic nine_bit_mode_i,
  // Transmitter side
  input wire logic tx_shift_ready_i,
  input wire logic tx_busy_i,
  input wire logic tx_queued_i,
  output logic tx_load_o,
  output logic [8:0] tx_shift_data_o,
  // Service requests
  output sci_flags_pkg::svc_req_t req_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave

  sci_flags_pkg::bus_state_t bus_ff; // Access phase
  sci_flags_pkg::bus_state_t nxt_bus;
  logic [31:0] rdata_ff; // Registered read data
  logic [31:0] nxt_rdata;
  wire req = avs_read_i | avs_write_i;
  // An access is taken at the edge where waitrequest is low
  wire take = (bus_ff == sci_flags_pkg::BUS_ANSWER) & req;
  // Unaligned addresses select nothing: reads give zero, writes are lost
  wire aligned = (avs_address_i[1:0] == 2'h0);
  wire sel_data = aligned & (avs_address_i == `OFS_DATA);
  wire sel_c2 = aligned & (avs_address_i == `OFS_CTRL2);
  wire sel_c3 = aligned & (avs_address_i == `OFS_CTRL3);
  wire sel_s1 = aligned & (avs_address_i == `OFS_STAT1);
  wire wr_lane = take & avs_write_i & avs_byteenable_i[0];
  wire rd_take = take & avs_read_i;
  wire cpu_dwr = wr_lane & sel_data; // CPU data write
  wire cpu_drd = rd_take & sel_data; // CPU data read
  wire cpu_s1rd = rd_take & sel_s1; // CPU status one read

  // One wait cycle: the answer is always exactly one cycle after the request
  always_comb begin
    case (bus_ff)
      sci_flags_pkg::BUS_IDLE: nxt_bus = req ? sci_flags_pkg::BUS_ANSWER : sci_flags_pkg::BUS_IDLE;
      sci_flags_pkg::BUS_ANSWER: nxt_bus = sci_flags_pkg::BUS_IDLE;
      default: nxt_bus = sci_flags_pkg::BUS_IDLE;
    endcase
  end

  // Phase register and the waitrequest flop
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bus_ff <= sci_flags_pkg::BUS_IDLE;
      avs_waitrequest_o <= 1'b1;
    end else begin
      bus_ff <= nxt_bus;
      avs_waitrequest_o <= (nxt_bus != sci_flags_pkg::BUS_ANSWER);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  logic [4:0] ctrl2_ff; // Enables and transmitter enable
  logic [5:0] ctrl3_ff; // DMA enables and error enables
  logic ninth_tx_bit_ff; // Kept through reset
  logic te_seen_ff; // Transmitter has been enabled once
  // Field views of the control registers
  wire tx_empty_irq_en = ctrl2_ff[4];
  wire tx_complete_irq_en = ctrl2_ff[3];
  wire rx_full_irq_en = ctrl2_ff[2];
  wire idle_irq_en = ctrl2_ff[1];
  wire tx_enable_bit = ctrl2_ff[0];
  wire rx_dma_req_en = ctrl3_ff[5];
  wire tx_dma_req_en = ctrl3_ff[4];
  wire [3:0] err_irq_en = ctrl3_ff[3:0];
  wire cpu_c2_wr = wr_lane & sel_c2;
  wire cpu_c2_wr_te = cpu_c2_wr & avs_writedata_i[`C2_TX_ENABLE];
  // Only the very first enable counts; later toggles leave the empty flag alone
  wire te_first = cpu_c2_wr_te & ~te_seen_ff;

  // Control writes; overrun enable takes zero at reset as a safe choice
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl2_ff <= `RST_CTRL2;
      ctrl3_ff <= `RST_CTRL3;
      te_seen_ff <= 1'b0;
    end else begin
      if (cpu_c2_wr) begin
        ctrl2_ff <= avs_writedata_i[`C2_TX_EMPTY_IE:`C2_TX_ENABLE];
      end
      if (wr_lane & sel_c3) begin
        ctrl3_ff <= avs_writedata_i[`C3_RX_DMA:0];
      end
      if (cpu_c2_wr_te) begin
        te_seen_ff <= 1'b1;
      end
    end
  end

  // Ninth transmit bit has no reset on purpose
  always_ff @(posedge clk_sys_i) begin
    if (wr_lane & sel_c3) begin
      ninth_tx_bit_ff <= avs_writedata_i[`C3_NINTH_TX];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit holding register

  logic [7:0] tx_hold_ff; // Character waiting for the shifter
  logic tx_full_ff; // Holding register occupied
  wire any_dwr = cpu_dwr | dma_wr_i;
  // DMA wins when both write the data register in one cycle
  wire [7:0] wr_byte = dma_wr_i ? dma_wdata_i : avs_writedata_i[7:0];
  // Hand over only while the transmitter is enabled and the shifter is free;
  // the ready level lags the load strobe by a cycle, so no second hand-over then
  wire hand_over = tx_full_ff & tx_shift_ready_i & tx_enable_bit & ~tx_load_o;

  // Holding register data is not reset
  always_ff @(posedge clk_sys_i) begin
    if (any_dwr) begin
      tx_hold_ff <= wr_byte;
    end
    if (hand_over) begin
      tx_shift_data_o <= {ninth_tx_bit_ff, tx_hold_ff};
    end
  end

  // Occupancy and the one-cycle load strobe
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_full_ff <= 1'b0;
      tx_load_o <= 1'b0;
    end else begin
      tx_full_ff <= any_dwr | (tx_full_ff & ~hand_over);
      tx_load_o <= hand_over;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive holding register

  logic [7:0] rx_hold_ff; // Received character
  logic ninth_rx_bit_ff; // Kept through reset
  logic rx_en_d_ff; // Receiver enable one cycle ago
  logic idle_allow_ff; // Idle may set once more
  logic [7:0] stat_ff; // Status one flags
  logic [7:0] arm_ff; // Flags seen set by the last status read
  // A character is taken only while the holding register is empty
  wire rx_take = rx_ev_i.load & ~stat_ff[`ST_RX_FULL];
  wire rx_over = rx_ev_i.load & stat_ff[`ST_RX_FULL];

  // Data and ninth bit move together, unaffected by reset
  always_ff @(posedge clk_sys_i) begin
    if (rx_take) begin
      rx_hold_ff <= rx_ev_i.data[7:0];
      ninth_rx_bit_ff <= nine_bit_mode_i ? rx_ev_i.data[8] : rx_ev_i.data[7];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags

  logic [7:0] set_v; // Set terms per flag
  logic [7:0] clr_v; // Clear terms per flag
  logic [7:0] nxt_stat;
  // Receiver enable edge restarts the wait for a character
  wire rx_rise = rx_enable_i & ~rx_en_d_ff;
  wire idle_set = rx_idle_i & idle_allow_ff;

  // Set and clear terms; set wins over clear for every sticky flag
  always_comb begin
    set_v = 8'h00;
    clr_v = 8'h00;
    set_v[`ST_TX_EMPTY] = hand_over | te_first;
    clr_v[`ST_TX_EMPTY] = (cpu_dwr & arm_ff[`ST_TX_EMPTY]) | dma_wr_i;
    set_v[`ST_RX_FULL] = rx_take;
    clr_v[`ST_RX_FULL] = (cpu_drd & arm_ff[`ST_RX_FULL]) | dma_rd_i;
    set_v[`ST_IDLE] = idle_set;
    set_v[`ST_OVERRUN] = rx_over;
    set_v[`ST_NOISE] = rx_take & rx_ev_i.noise;
    set_v[`ST_FRAMING] = rx_take & rx_ev_i.framing;
    set_v[`ST_PARITY] = rx_take & rx_ev_i.parity;
    // Idle and error flags clear on a CPU data read only when armed
    clr_v[`ST_IDLE:`ST_PARITY] = {5{cpu_drd}} & arm_ff[`ST_IDLE:`ST_PARITY];
    nxt_stat = set_v | (stat_ff & ~clr_v);
    // Complete flag is a level: queueing wins over the quiet condition
    if (tx_queued_i | any_dwr) begin
      nxt_stat[`ST_TX_DONE] = 1'b0;
    end else if (nxt_stat[`ST_TX_EMPTY] & ~tx_busy_i & ~tx_full_ff) begin
      nxt_stat[`ST_TX_DONE] = 1'b1;
    end else begin
      nxt_stat[`ST_TX_DONE] = stat_ff[`ST_TX_DONE];
    end
  end

  // Flag, arm and idle bookkeeping registers
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stat_ff <= `RST_STAT1;
      arm_ff <= 8'h00;
      rx_en_d_ff <= 1'b0;
      idle_allow_ff <= 1'b0;
    end else begin
      stat_ff <= nxt_stat;
      rx_en_d_ff <= rx_enable_i;
      // Each status read replaces the arms; a used arm is dropped
      if (cpu_s1rd) begin
        // Arm only flags that the returned word showed and that still stand
        arm_ff <= rdata_ff[7:0] & stat_ff;
      end else begin
        arm_ff <= arm_ff & ~clr_v;
      end
      // Idle waits for a full character after enable, set or clear
      if (rx_take) begin
        idle_allow_ff <= 1'b1;
      end else if (rx_rise | idle_set | clr_v[`ST_IDLE]) begin
        idle_allow_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data and request routing

  wire [7:0] ctrl2_rd = {ctrl2_ff, 3'h0};
  wire [7:0] ctrl3_rd = {ninth_rx_bit_ff, ninth_tx_bit_ff, ctrl3_ff};
  wire [7:0] rd_sel = sel_data ? rx_hold_ff : sel_c2 ? ctrl2_rd : sel_c3 ? ctrl3_rd : sel_s1 ? stat_ff : 8'h00;
  // Requests follow the flags; the output flop adds one cycle
  wire rx_dma_n = stat_ff[`ST_RX_FULL] & rx_full_irq_en & rx_dma_req_en;
  wire tx_dma_n = stat_ff[`ST_TX_EMPTY] & tx_empty_irq_en & tx_dma_req_en;
  wire rx_irq_n = ~rx_dma_req_en & ((stat_ff[`ST_RX_FULL] & rx_full_irq_en) |
    (stat_ff[`ST_IDLE] & idle_irq_en));
  wire tx_irq_n = (stat_ff[`ST_TX_EMPTY] & tx_empty_irq_en & ~tx_dma_req_en) |
    (stat_ff[`ST_TX_DONE] & tx_complete_irq_en);
  // Error requests stay on under receive DMA
  wire err_irq_n = |(stat_ff[`ST_OVERRUN:`ST_PARITY] & err_irq_en);

  always_comb begin
    nxt_rdata = {24'h000000, rd_sel};
  end

  // Registered outputs
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_ff <= 32'h00000000;
      req_o <= '0;
      dma_rdata_o <= 8'h00;
    end else begin
      if (nxt_bus == sci_flags_pkg::BUS_ANSWER) begin
        rdata_ff <= nxt_rdata;
      end
      req_o <= '{rx_dma: rx_dma_n, tx_dma: tx_dma_n, rx_irq: rx_irq_n, tx_irq: tx_irq_n, err_irq: err_irq_n};
      dma_rdata_o <= rx_hold_ff;
    end
  end

  assign avs_readdata_o = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  // Routing of flags to requests, then flag, data and bus checks
  a_rx_dma_route: assert property (stat_ff[`ST_RX_FULL] && rx_full_irq_en && rx_dma_req_en
    |=> req_o.rx_dma && !req_o.rx_irq)
    else $error("rx full not routed to dma");
  a_tx_cpu_route: assert property (stat_ff[`ST_TX_EMPTY] && tx_empty_irq_en && !tx_dma_req_en
    |=> req_o.tx_irq && !req_o.tx_dma)
    else $error("tx empty not routed to cpu");
  a_rx_dma_mute: assert property (rx_dma_req_en |=> !req_o.rx_irq)
    else $error("receiver irq while rx dma on");
  a_err_irq_or: assert property (stat_ff[`ST_OVERRUN] && err_irq_en[3] |=> req_o.err_irq)
    else $error("overrun irq missing");
  a_load_sets_empty: assert property (hand_over |=> stat_ff[`ST_TX_EMPTY] ##1 tx_load_o == 1'b0)
    else $error("hand over did not set empty");
  a_dma_wr_clear: assert property (dma_wr_i && !hand_over && !te_first
    |=> !stat_ff[`ST_TX_EMPTY] && !stat_ff[`ST_TX_DONE])
    else $error("dma write did not clear flags");
  a_queue_clears_tc: assert property (tx_queued_i |=> !stat_ff[`ST_TX_DONE])
    else $error("complete flag held while queued");
  a_overrun_keeps: assert property (rx_over |=> stat_ff[`ST_OVERRUN] && $stable(rx_hold_ff))
    else $error("overrun changed holding data");
  a_or_not_armed: assert property (cpu_drd && !arm_ff[`ST_OVERRUN] && stat_ff[`ST_OVERRUN]
    |=> stat_ff[`ST_OVERRUN])
    else $error("unarmed read cleared overrun");
  a_idle_needs_char: assert property (($rose(rx_enable_i) && !rx_take) ##1 (!rx_take)[*2]
    |-> !idle_allow_ff)
    else $error("idle allowed without a character");
  a_ninth_copy: assert property (rx_take && !nine_bit_mode_i |=> ninth_rx_bit_ff == rx_hold_ff[7])
    else $error("ninth rx bit not a copy of bit 7");
  a_wait_one: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o) // One wait cycle
    else $error("answer not one cycle after request");
  a_rx_cpu_route: assert property (stat_ff[`ST_RX_FULL] && rx_full_irq_en && !rx_dma_req_en
    |=> req_o.rx_irq && !req_o.rx_dma)
    else $error("rx full not routed to cpu");
  a_tx_dma_route: assert property (stat_ff[`ST_TX_EMPTY] && tx_empty_irq_en && tx_dma_req_en
    |=> req_o.tx_dma)
    else $error("tx empty not routed to dma");
  // Flag set and clear terms
  a_te_first_sets: assert property (te_first |=> stat_ff[`ST_TX_EMPTY])
    else $error("first transmitter enable did not set empty");
  a_done_when_quiet: assert property (stat_ff[`ST_TX_EMPTY] && !tx_busy_i && !tx_full_ff
    && !tx_queued_i && !any_dwr |=> stat_ff[`ST_TX_DONE])
    else $error("complete flag not set while quiet");
  a_full_on_take: assert property (rx_take |=> stat_ff[`ST_RX_FULL])
    else $error("received character did not set full");
  a_dma_rd_clear: assert property (dma_rd_i && !rx_take |=> !stat_ff[`ST_RX_FULL])
    else $error("dma read did not clear full");
  a_idle_sets: assert property (idle_set |=> stat_ff[`ST_IDLE])
    else $error("idle line did not set idle flag");
  a_noise_sets: assert property (rx_take && rx_ev_i.noise |=> stat_ff[`ST_NOISE])
    else $error("noise did not set noise flag");
  // Data path
  a_ninth_nine: assert property (rx_take && nine_bit_mode_i
    |=> ninth_rx_bit_ff == $past(rx_ev_i.data[8]))
    else $error("ninth rx bit not captured");
  a_shift_ninth: assert property (hand_over
    |=> tx_load_o && tx_shift_data_o == {$past(ninth_tx_bit_ff), $past(tx_hold_ff)})
    else $error("shifter word not ninth bit and data");

  c_rx_dma: cover property (req_o.rx_dma ##[1:20] dma_rd_i);
  c_overrun: cover property (rx_over ##[1:50] cpu_drd);
  c_tx_chain: cover property (cpu_dwr ##[1:40] tx_load_o);
  c_idle: cover property (idle_set);

endmodule
`default_nettype wire

/* rtl/sci_flags_consts.svh */
// Offsets, field positions, reset values and notes for the serial flag block
// Notes on behaviour
// - Nine-bit mode: ninth received bit stored with data
// - Eight-bit mode: ninth rx bit copies bit 7
// - Ninth tx bit loads as shifter bit 8
// - Receiver full routes to DMA or CPU
// - Transmitter empty routes to DMA or CPU
// - Receive DMA mutes receiver CPU interrupts
// - Error flags raise error interrupt when enabled
// - Handing character to shifter sets empty flag
// - Armed data write or DMA write clears empty
// - First transmitter enable sets empty flag
// - Complete flag set when empty and quiet
// - Complete flag cleared when anything is queued
// - DMA data write clears complete flag
// - Receiver full set on transfer, cleared by read
// - Idle flag set on idle line, routed
// - Idle rearmed only by a full character
// - Overrun discards new data, keeps holding register
// - Overrun cleared only when read status saw it
// - Noise flag set on noise, read-sequence clear
// - Framing flag set on zero stop bit
// - Parity flag set on parity mismatch
`ifndef SCI_FLAGS_CONSTS_SVH
`define SCI_FLAGS_CONSTS_SVH
// Byte offsets on the register bus
`define OFS_DATA 4'h0
`define OFS_CTRL2 4'h4
`define OFS_CTRL3 4'h8
`define OFS_STAT1 4'hC
// Status one bit positions
`define ST_TX_EMPTY 7
`define ST_TX_DONE 6
`define ST_RX_FULL 5
`define ST_IDLE 4
`define ST_OVERRUN 3
`define ST_NOISE 2
`define ST_FRAMING 1
`define ST_PARITY 0
// Control two bit positions
`define C2_TX_EMPTY_IE 7
`define C2_TX_DONE_IE 6
`define C2_RX_FULL_IE 5
`define C2_IDLE_IE 4
`define C2_TX_ENABLE 3
// Control three bit positions (3..0 are the error enables, same order as status)
`define C3_NINTH_RX 7
`define C3_NINTH_TX 6
`define C3_RX_DMA 5
`define C3_TX_DMA 4
// Reset values
`define RST_STAT1 8'hC0
`define RST_CTRL2 5'h00
`define RST_CTRL3 6'h00
`endif

/* rtl/sci_flags_pkg.sv */
// Types shared by the serial flag block and its neighbours
package sci_flags_pkg;
  // One completed character from the receive shifter
  typedef struct packed {
    logic load;
    logic [8:0] data;
    logic noise;
    logic framing;
    logic parity;
  } rx_event_t;
  // Service requests towards the CPU and the DMA controller
  typedef struct packed {
    logic rx_dma;
    logic tx_dma;
    logic rx_irq;
    logic tx_irq;
    logic err_irq;
  } svc_req_t;
  // Bus access phase
  typedef enum logic [1:0] {BUS_IDLE, BUS_ANSWER} bus_state_t;
endpackage

/* dv/sci_far_side.sv */
// Far-side model: transmit shifter, receive shifter and idle detector
`timescale 1ns/100ps
`default_nettype none
module sci_far_side #(
  parameter int BUSY_CYC = 20
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // Transmit shifter
  input wire logic tx_load_i,
  input wire logic [8:0] tx_data_i,
  output logic tx_shift_ready_o,
  output logic tx_busy_o,
  output logic tx_queued_o,
  output logic [8:0] last_tx_o,
  // Receive shifter
  output sci_flags_pkg::rx_event_t rx_ev_o,
  output logic rx_idle_o
);
  int cnt_ff; // Bit times left in the current character
  // Shifter is busy while a character is counted down
  assign tx_busy_o = (cnt_ff != 0);
  assign tx_shift_ready_o = (cnt_ff == 0);
  // Queueing is seen the cycle the shifter takes a character
  assign tx_queued_o = tx_load_i;
  ////////////////////////////////////////////////////////////////////////
  // Capture each loaded character, nine bits wide
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_ff <= 0;
    end else if (tx_load_i) begin
      cnt_ff <= BUSY_CYC;
      last_tx_o <= tx_data_i;
    end else if (cnt_ff != 0) begin
      cnt_ff <= cnt_ff - 1;
    end
  end
  initial begin
    rx_ev_o = '0;
    rx_idle_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // One completed character; stale data is inverted so it is never reused
  task automatic rx_char(input logic [8:0] d, input logic [2:0] e);
    @(posedge clk_sys_i);
    rx_ev_o <= {1'b1, d, e}; // Flags in noise, framing, parity order
    @(posedge clk_sys_i);
    rx_ev_o <= {1'b0, ~d, 3'b000};
    repeat (2) @(posedge clk_sys_i);
  endtask
  // Idle line seen after a full character time of ones
  task automatic idle;
    @(posedge clk_sys_i);
    rx_idle_o <= 1'b1;
    @(posedge clk_sys_i);
    rx_idle_o <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
  endtask
endmodule
`default_nettype wire

/* dv/tb.sv */
// Self-checking bench for the serial flag and request block
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [3:0] ben = 4'hF;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic wreq;
  logic dma_rd = 1'b0;
  logic dma_wr = 1'b0;
  logic [7:0] dma_wd = 8'h00;
  logic [7:0] dma_rdata;
  sci_flags_pkg::rx_event_t rx_ev;
  logic rx_idle;
  logic rx_en = 1'b0;
  logic nine = 1'b0;
  logic ready, busy, queued, load;
  logic [8:0] sdat;
  logic [8:0] last_tx;
  sci_flags_pkg::svc_req_t req;
  int err_count = 0;
  int n_tests = 0;
  logic [31:0] got;
  // 40 MHz system clock
  always #12.5 clk_sys_i = ~clk_sys_i;
  sci_flags_and_request_routing u_sci_flags_and_request_routing (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_byteenable_i(ben), .avs_writedata_i(wdat), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .dma_rd_i(dma_rd), .dma_wr_i(dma_wr), .dma_wdata_i(dma_wd),
    .dma_rdata_o(dma_rdata), .rx_ev_i(rx_ev), .rx_idle_i(rx_idle), .rx_enable_i(rx_en),
    .nine_bit_mode_i(nine), .tx_shift_ready_i(ready), .tx_busy_i(busy), .tx_queued_i(queued),
    .tx_load_o(load), .tx_shift_data_o(sdat), .req_o(req));
  sci_far_side u_far (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .tx_load_i(load), .tx_data_i(sdat),
    .tx_shift_ready_o(ready), .tx_busy_o(busy), .tx_queued_o(queued), .last_tx_o(last_tx),
    .rx_ev_o(rx_ev), .rx_idle_o(rx_idle));
  ////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic final_report;
    $display("Checks %0d, errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk_sys_i);
    adr <= a;
    wdat <= {24'h0, d};
    rd <= !w;
    wr <= w;
    do begin
      @(posedge clk_sys_i);
      k++;
    end while (wreq !== 1'b0 && k < 20);
    got = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (wreq !== 1'b0) begin
      err_count++;
      final_report;
    end
  endtask
  // Read a register and compare the masked byte
  task automatic rchk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(got & {24'h0, m}, {24'h0, e});
  endtask
  // Requests lag the flags, so let them settle first
  task automatic rq(input logic [4:0] e);
    repeat (3) @(posedge clk_sys_i);
    chk({27'h0, req}, {27'h0, e});
  endtask
  // One DMA access pulse
  task automatic dma(input logic w, input logic [7:0] d);
    @(posedge clk_sys_i);
    dma_wr <= w;
    dma_rd <= !w;
    dma_wd <= d;
    @(posedge clk_sys_i);
    dma_wr <= 1'b0;
    dma_rd <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    rx_en <= 1'b1;
    rchk(4'hC, 8'hFF, 8'hC0);
    rchk(4'h4, 8'hFF, 8'h00);
    rchk(4'h8, 8'h3F, 8'h00);
    rchk(4'h2, 8'hFF, 8'h00);
    // Writes with lane 0 off or to an unaligned address are dropped
    ben <= 4'hE;
    bus(1'b1, 4'h4, 8'hF8);
    ben <= 4'hF;
    bus(1'b1, 4'h6, 8'hF8);
    rchk(4'h4, 8'hFF, 8'h00);
    rchk(4'hC, 8'hFF, 8'hC0);
    // DMA enabled ahead of the transmitter, so no CPU request appears
    bus(1'b1, 4'h8, 8'h10);
    bus(1'b1, 4'h4, 8'h88);
    rq(5'b01000);
    // CPU data writes only with transmit DMA off
    bus(1'b1, 4'h8, 8'h40);
    rq(5'b00010);
    rchk(4'hC, 8'hFF, 8'hC0);
    bus(1'b1, 4'h0, 8'hA5);
    repeat (4) @(posedge clk_sys_i);
    chk({23'h0, last_tx}, 32'h1A5);
    rchk(4'hC, 8'hFF, 8'h80);
    bus(1'b1, 4'h0, 8'h3C);
    rchk(4'hC, 8'hFF, 8'h00);
    repeat (50) @(posedge clk_sys_i);
    chk({23'h0, last_tx}, 32'h13C);
    rchk(4'hC, 8'hFF, 8'hC0);
    // DMA writes clear empty and complete without a status read
    bus(1'b1, 4'h8, 8'h10);
    dma(1'b1, 8'h5A);
    repeat (4) @(posedge clk_sys_i);
    chk({23'h0, last_tx}, 32'h05A);
    dma(1'b1, 8'hC3);
    rchk(4'hC, 8'hFF, 8'h00);
    repeat (50) @(posedge clk_sys_i);
    chk({23'h0, last_tx}, 32'h0C3);
    bus(1'b1, 4'h8, 8'h00);
    bus(1'b1, 4'h4, 8'h48);
    rq(5'b00010);
    // Receive: nine-bit then eight-bit characters
    bus(1'b1, 4'h8, 8'h0F);
    bus(1'b1, 4'h4, 8'h38);
    nine <= 1'b1;
    u_far.rx_char(9'h15A, 3'b000);
    rq(5'b00100);
    rchk(4'h8, 8'h80, 8'h80);
    rchk(4'hC, 8'hFF, 8'hE0);
    rchk(4'h0, 8'hFF, 8'h5A);
    rchk(4'hC, 8'hFF, 8'hC0);
    nine <= 1'b0;
    u_far.rx_char(9'h080, 3'b000);
    rchk(4'h8, 8'h80, 8'h80);
    u_far.rx_char(9'h011, 3'b000);
    rq(5'b00101);
    rchk(4'hC, 8'hFF, 8'hE8);
    rchk(4'h0, 8'hFF, 8'h80);
    rchk(4'hC, 8'hFF, 8'hC0);
    u_far.rx_char(9'h07F, 3'b000);
    rchk(4'h8, 8'h80, 8'h00);
    rchk(4'hC, 8'hFF, 8'hE0);
    u_far.rx_char(9'h022, 3'b000);
    rchk(4'h0, 8'hFF, 8'h7F);
    rchk(4'hC, 8'hFF, 8'hC8);
    rchk(4'h0, 8'hFF, 8'h7F);
    rchk(4'hC, 8'hFF, 8'hC0);
    // Each receive error flag in turn: parity, framing, noise
    for (int i = 0; i < 3; i++) begin
      u_far.rx_char(9'h033, 3'b001 << i);
      rq(5'b00101);
      rchk(4'hC, 8'hFF, 8'hE0 | (8'h01 << i));
      rchk(4'h0, 8'hFF, 8'h33);
      rq(5'b00000);
    end
    // Idle detection and rearming
    u_far.idle();
    rq(5'b00100);
    rchk(4'hC, 8'hFF, 8'hD0);
    rchk(4'h0, 8'hFF, 8'h33);
    rchk(4'hC, 8'hFF, 8'hC0);
    u_far.idle();
    rchk(4'hC, 8'hFF, 8'hC0);
    // Receive DMA: CPU reads of data avoided, requests go to DMA
    bus(1'b1, 4'h8, 8'h2F);
    u_far.rx_char(9'h0AB, 3'b000);
    rq(5'b10000);
    u_far.idle();
    rq(5'b10000);
    rchk(4'hC, 8'h10, 8'h10);
    dma(1'b0, 8'h00);
    chk({24'h0, dma_rdata}, 32'h0AB);
    rchk(4'hC, 8'h20, 8'h00);
    // Mid-run reset: enables and flags return, ninth bits survive
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    rchk(4'h8, 8'hFF, 8'h80);
    rchk(4'hC, 8'hFF, 8'hC0);
    rq(5'b00000);
    final_report;
  end
endmodule
`default_nettype wire
